// *** hdl/pms_device.sv ***
// pms_device: power mode sequencer of the metering device: mode decode,
// transitions with register default/retain, mean absolute values, low power check.
// assumes one clock shared with the host; phase samples arrive with a valid strobe.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pms_device #(
    parameter int SAMPLE_W = 24,
    parameter int MAV_SHIFT = 4,
    parameter int LP_UNIT_CYC = pms_pkg::LP_UNIT_CYC_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link to the host
    pms_link_if.dev link,
    // phase current samples
    input wire logic sample_valid_i,
    input wire logic [2:0][SAMPLE_W-1:0] ph_net_i,
    input wire logic [2:0][SAMPLE_W-1:0] ph_pos_i,
    // status
    output pms_pkg::pms_mode_t mode_o,
    output logic busy_o
);
    import pms_pkg::*;

    localparam int SEG_W = $clog2(LP_UNIT_CYC + 1);

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        pms_mode_t mode;
        logic busy;
        logic [TCNT_W-1:0] tcnt;
        logic done;
        logic mav_go;
        logic lp_a;
        logic lp_b;
        logic win_on;
        logic [SEG_W-1:0] seg;
        logic [4:0] per;
        logic [2:0] above;
        logic [2:0][LPC_W-1:0] cnt;
        logic [15:0] mask;
        logic [7:0] lp_lvl;
        logic [7:0] cfg2;
        logic [2:0] gain;
        logic [2:0][MAV_W-1:0] mav;
        logic [DATA_W-1:0] rdata;
    } pms_dev_st_t;

    pms_dev_st_t s_r;
    pms_dev_st_t s_nxt;

    always_comb begin
        pms_mode_t req;
        logic stable;
        logic [SAMPLE_W-1:0] absv;
        logic [MAV_W-1:0] mag;
        logic [SAMPLE_W-1:0] thr;
        logic hit;
        logic [LPC_W-1:0] lim;
        req = pms_decode(s_r.sync2);
        stable = 1'b0;
        absv = '0;
        mag = '0;
        thr = '0;
        hit = 1'b0;
        lim = '0;
        s_nxt = s_r;
        s_nxt.rdata = '0;
        // pin synchroniser, first stage read only by the second
        s_nxt.sync1 = {link.mode_hi, link.mode_lo};
        s_nxt.sync2 = s_r.sync1;

        if (req != s_r.mode) begin
            // flags of the old mode end with it; done reads 0 through the transition
            s_nxt.mode = req;
            s_nxt.busy = !(req == PMS_REDUCED && s_r.mode == PMS_NORMAL);
            s_nxt.tcnt = TCNT_W'(TRANS_CYC - 1);
            s_nxt.done = 1'b0;
            s_nxt.mav_go = 1'b0;
            s_nxt.lp_a = 1'b0;
            s_nxt.lp_b = 1'b0;
            s_nxt.win_on = 1'b0;
            if (req == PMS_NORMAL) begin
                // level and secondary_config_reg keep their contents
                s_nxt.mask = MASK_RST;
                s_nxt.gain = GAIN_RST;
            end
        end else if (s_r.busy) begin
            if (s_r.tcnt == '0) begin
                s_nxt.busy = 1'b0;
                unique case (s_r.mode)
                    PMS_NORMAL: s_nxt.done = 1'b1;
                    PMS_REDUCED: s_nxt.mav_go = 1'b1;
                    PMS_LOW: begin
                        s_nxt.win_on = 1'b1;
                        s_nxt.seg = '0;
                        s_nxt.per = '0;
                        s_nxt.cnt = '0;
                        s_nxt.above = '0;
                    end
                    PMS_SLEEP: ;
                endcase
            end else begin
                s_nxt.tcnt = s_r.tcnt - 1'b1;
            end
        end else begin
            stable = 1'b1;
        end

        // register port: full in normal, mean reads only in reduced, silent otherwise
        if (stable && link.sp_rd) begin
            if (s_r.mode == PMS_NORMAL) begin
                unique case (link.sp_addr)
                    REG_STATUS_B: s_nxt.rdata[DONE_BIT] = s_r.done;
                    REG_MASK_B: s_nxt.rdata[15:0] = s_r.mask;
                    REG_LP_LEVEL: s_nxt.rdata[7:0] = s_r.lp_lvl;
                    REG_SECONDARY_CONFIG_REG: s_nxt.rdata[7:0] = s_r.cfg2;
                    REG_GAIN: s_nxt.rdata[2:0] = s_r.gain;
                    REG_MAV_A: s_nxt.rdata[MAV_W-1:0] = s_r.mav[0];
                    REG_MAV_B: s_nxt.rdata[MAV_W-1:0] = s_r.mav[1];
                    REG_MAV_C: s_nxt.rdata[MAV_W-1:0] = s_r.mav[2];
                    default: s_nxt.rdata = '0;
                endcase
            end else if (s_r.mode == PMS_REDUCED && pms_is_mav(link.sp_addr)) begin
                unique case (link.sp_addr)
                    REG_MAV_A: s_nxt.rdata[MAV_W-1:0] = s_r.mav[0];
                    REG_MAV_B: s_nxt.rdata[MAV_W-1:0] = s_r.mav[1];
                    default: s_nxt.rdata[MAV_W-1:0] = s_r.mav[2];
                endcase
            end
        end
        if (stable && link.sp_wr && s_r.mode == PMS_NORMAL) begin
            unique case (link.sp_addr)
                REG_STATUS_B: begin
                    if (link.sp_wdata[DONE_BIT]) begin
                        s_nxt.done = 1'b0;
                    end
                end
                REG_MASK_B: s_nxt.mask = link.sp_wdata[15:0];
                REG_LP_LEVEL: s_nxt.lp_lvl = link.sp_wdata[7:0];
                REG_SECONDARY_CONFIG_REG: s_nxt.cfg2 = link.sp_wdata[7:0];
                REG_GAIN: s_nxt.gain = link.sp_wdata[2:0];
                default: ;
            endcase
        end

        // mean absolute value, a first order average of |net current|
        if (stable && sample_valid_i && (s_r.mode == PMS_NORMAL || s_r.mode == PMS_REDUCED))
        begin
            for (int i = 0; i < 3; i++) begin
                absv = ph_net_i[i][SAMPLE_W-1] ? SAMPLE_W'(-ph_net_i[i]) : ph_net_i[i];
                mag = absv[SAMPLE_W-2 -: MAV_W];
                s_nxt.mav[i] = s_r.mav[i] - (s_r.mav[i] >> MAV_SHIFT) + (mag >> MAV_SHIFT);
            end
        end

        // low power window
        if (stable && s_r.mode == PMS_LOW && s_r.win_on) begin
            thr = {1'b0, s_r.lp_lvl[LP_THR_LSB +: 3], {(SAMPLE_W-4){1'b0}}};
            if (sample_valid_i) begin
                for (int i = 0; i < 3; i++) begin
                    // positive terminal only, one count per rise above threshold
                    hit = $signed(ph_pos_i[i]) > $signed(thr);
                    s_nxt.above[i] = hit;
                    if (hit && !s_r.above[i] && s_r.cnt[i] != '1) begin
                        s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
                    end
                end
            end
            if (s_r.seg == SEG_W'(LP_UNIT_CYC - 1)) begin
                s_nxt.seg = '0;
                if (s_r.per == s_r.lp_lvl[LP_PER_LSB +: 5]) begin
                    lim = LPC_W'(s_r.lp_lvl[LP_PER_LSB +: 5]) + 1'b1;
                    s_nxt.win_on = 1'b0;
                    if (s_r.cnt[0] >= lim || s_r.cnt[1] >= lim || s_r.cnt[2] >= lim) begin
                        s_nxt.lp_b = 1'b1;
                    end else begin
                        s_nxt.lp_a = 1'b1;
                    end
                end else begin
                    s_nxt.per = s_r.per + 1'b1;
                end
            end else begin
                s_nxt.seg = s_r.seg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.sync1 <= PIN_NORMAL;
            s_r.sync2 <= PIN_NORMAL;
            s_r.mode <= PMS_NORMAL;
            s_r.mask <= MASK_RST;
            s_r.lp_lvl <= LP_LEVEL_RST;
            s_r.cfg2 <= SECONDARY_CONFIG_REG_RST;
            s_r.gain <= GAIN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // done drives line B whatever the mask holds
    assign link.irq_b_n = !(s_r.done || s_r.mav_go || s_r.lp_b);
    assign link.irq_a_n = !s_r.lp_a;
    assign link.sp_rdata = s_r.rdata;
    assign mode_o = s_r.mode;
    assign busy_o = s_r.busy;

endmodule // pms_device

// *** inc/pms_pkg.sv ***
// pms_pkg: modes, pin codes, register map, field layout, reset values and timing
// of the power mode sequencer and its host; used by both ends and the link interface.
package pms_pkg;

    typedef enum logic [1:0] {PMS_NORMAL, PMS_REDUCED, PMS_LOW, PMS_SLEEP} pms_mode_t;

    // pin pair written {high pin, low pin}
    localparam logic [1:0] PIN_NORMAL = 2'h1;
    localparam logic [1:0] PIN_REDUCED = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h2;
    localparam logic [1:0] PIN_SLEEP = 2'h3;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MAV_W = 20;
    localparam int LPC_W = 6;
    localparam int TCNT_W = 8;

    // device register offsets
    localparam logic [7:0] REG_STATUS_B = 8'h00;
    localparam logic [7:0] REG_MASK_B = 8'h04;
    localparam logic [7:0] REG_LP_LEVEL = 8'h08;
    localparam logic [7:0] REG_SECONDARY_CONFIG_REG = 8'h0C;
    localparam logic [7:0] REG_GAIN = 8'h10;
    localparam logic [7:0] REG_MAV_A = 8'h14;
    localparam logic [7:0] REG_MAV_B = 8'h18;
    localparam logic [7:0] REG_MAV_C = 8'h1C;

    localparam int DONE_BIT = 15;
    localparam int LP_THR_LSB = 0;
    localparam int LP_PER_LSB = 3;
    localparam logic [7:0] LP_LEVEL_RST = 8'h07;
    localparam logic [7:0] SECONDARY_CONFIG_REG_RST = 8'h00;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [2:0] GAIN_RST = 3'h1;
    localparam logic [2:0] GAIN_OK_A = 3'h1;
    localparam logic [2:0] GAIN_OK_B = 3'h2;

    // host register offsets and bits
    localparam logic [7:0] H_CTRL = 8'h00;
    localparam logic [7:0] H_DATA = 8'h04;
    localparam logic [7:0] H_CMD = 8'h08;
    localparam logic [7:0] H_STAT = 8'h0C;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CMD_WR_BIT = 8;

    // timing at the 40 MHz system clock
    localparam int CLK_HZ = 40_000_000;
    localparam int LP_UNIT_MS = 20;
    localparam int LP_UNIT_CYC_DEF = CLK_HZ / 1000 * LP_UNIT_MS;
    localparam int TRANS_NS = 1000;
    localparam int TRANS_CYC = (TRANS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    function automatic pms_mode_t pms_decode(input logic [1:0] pins);
        unique case (pins)
            PIN_NORMAL: pms_decode = PMS_NORMAL;
            PIN_REDUCED: pms_decode = PMS_REDUCED;
            PIN_LOW: pms_decode = PMS_LOW;
            PIN_SLEEP: pms_decode = PMS_SLEEP;
        endcase
    endfunction

    function automatic logic [1:0] pms_encode(input pms_mode_t m);
        unique case (m)
            PMS_NORMAL: pms_encode = PIN_NORMAL;
            PMS_REDUCED: pms_encode = PIN_REDUCED;
            PMS_LOW: pms_encode = PIN_LOW;
            PMS_SLEEP: pms_encode = PIN_SLEEP;
        endcase
    endfunction

    function automatic logic pms_is_mav(input logic [7:0] a);
        pms_is_mav = (a == REG_MAV_A) || (a == REG_MAV_B) || (a == REG_MAV_C);
    endfunction

endpackage

// *** inc/pms_link_if.sv ***
// pms_link_if: mode pins, two interrupt lines and the register port between
// host and sequencer; both ends share clk_i, interrupt lines are active low.
`timescale 1ns/1ps
interface pms_link_if;
    logic mode_hi;
    logic mode_lo;
    logic irq_a_n;
    logic irq_b_n;
    logic [pms_pkg::ADDR_W-1:0] sp_addr;
    logic [pms_pkg::DATA_W-1:0] sp_wdata;
    logic sp_wr;
    logic sp_rd;
    logic [pms_pkg::DATA_W-1:0] sp_rdata;

    modport dev (
        input mode_hi, mode_lo, sp_addr, sp_wdata, sp_wr, sp_rd,
        output irq_a_n, irq_b_n, sp_rdata
    );
    modport host (
        output mode_hi, mode_lo, sp_addr, sp_wdata, sp_wr, sp_rd,
        input irq_a_n, irq_b_n, sp_rdata
    );
endinterface

// *** hdl/pms_host.sv ***
// pms_host: host controller that drives the mode pins, reacts to the interrupt
// lines and forwards software register accesses to the sequencer under mode limits.
// assumes one clock shared with the sequencer; software port strobes are one cycle.
`timescale 1ns/1ps
module pms_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link to the sequencer
    pms_link_if.host link,
    // software port
    input wire logic [pms_pkg::ADDR_W-1:0] addr_i,
    input wire logic [pms_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [pms_pkg::DATA_W-1:0] rdata_o
);
    import pms_pkg::*;

    typedef struct packed {
        pms_mode_t mode;
        logic [1:0] pins;
        logic auto_en;
        logic [2:0] gain;
        logic mav_ok;
        logic a_prev;
        logic b_prev;
        logic a_seen;
        logic b_seen;
        logic refused;
        logic rd_pend;
        logic [DATA_W-1:0] dwdata;
        logic [DATA_W-1:0] ddata;
        logic [ADDR_W-1:0] sp_addr;
        logic [DATA_W-1:0] sp_wdata;
        logic sp_wr;
        logic sp_rd;
        logic [DATA_W-1:0] urdata;
    } pms_host_st_t;

    pms_host_st_t s_r;
    pms_host_st_t s_nxt;

    always_comb begin
        logic a_low;
        logic b_low;
        logic a_fall;
        logic b_fall;
        logic req_v;
        pms_mode_t req;
        logic acc_wr;
        logic acc_ok;
        a_low = !link.irq_a_n;
        b_low = !link.irq_b_n;
        a_fall = a_low && !s_r.a_prev;
        b_fall = b_low && !s_r.b_prev;
        req_v = 1'b0;
        req = s_r.mode;
        acc_wr = wdata_i[CMD_WR_BIT];
        acc_ok = 1'b0;
        s_nxt = s_r;
        s_nxt.a_prev = a_low;
        s_nxt.b_prev = b_low;
        s_nxt.sp_wr = 1'b0;
        s_nxt.sp_rd = 1'b0;
        s_nxt.urdata = '0;
        s_nxt.rd_pend = s_r.sp_rd;
        if (s_r.rd_pend) begin
            s_nxt.ddata = link.sp_rdata;
        end

        // low power outcome answered by the next mode
        if (s_r.auto_en && s_r.mode == PMS_LOW) begin
            if (a_fall) begin
                req_v = 1'b1;
                req = PMS_SLEEP;
            end else if (b_fall) begin
                req_v = 1'b1;
                req = PMS_REDUCED;
            end
        end

        if (rd_i) begin
            unique case (addr_i)
                H_CTRL: s_nxt.urdata[2:0] = {s_r.auto_en, s_r.mode};
                // mean results go out raw; software holds the gain calibration
                H_DATA: s_nxt.urdata = s_r.ddata;
                H_STAT: s_nxt.urdata[5:0] = {s_r.mav_ok, s_r.refused, s_r.b_seen,
                    s_r.a_seen, b_low, a_low};
                default: s_nxt.urdata = '0;
            endcase
        end
        if (wr_i) begin
            unique case (addr_i)
                H_CTRL: begin
                    req_v = 1'b1;
                    req = pms_mode_t'(wdata_i[1:0]);
                    s_nxt.auto_en = wdata_i[CTRL_AUTO_BIT];
                end
                H_DATA: s_nxt.dwdata = wdata_i;
                H_CMD: begin
                    // nothing in low power or sleep; reduced allows mean reads once started
                    acc_ok = (s_r.mode == PMS_NORMAL) || (s_r.mode == PMS_REDUCED && !acc_wr
                        && pms_is_mav(wdata_i[ADDR_W-1:0]) && s_r.mav_ok);
                    if (acc_ok) begin
                        s_nxt.sp_addr = wdata_i[ADDR_W-1:0];
                        s_nxt.sp_wdata = s_r.dwdata;
                        s_nxt.sp_wr = acc_wr;
                        s_nxt.sp_rd = !acc_wr;
                        if (acc_wr && wdata_i[ADDR_W-1:0] == REG_GAIN) begin
                            s_nxt.gain = s_r.dwdata[2:0];
                        end
                    end else begin
                        s_nxt.refused = 1'b1;
                    end
                end
                H_STAT: begin
                    if (wdata_i[2]) s_nxt.a_seen = 1'b0;
                    if (wdata_i[3]) s_nxt.b_seen = 1'b0;
                    if (wdata_i[4]) s_nxt.refused = 1'b0;
                end
                default: ;
            endcase
        end

        // events after clears so that a set in the same cycle wins
        if (a_fall) s_nxt.a_seen = 1'b1;
        if (b_fall) s_nxt.b_seen = 1'b1;
        if (b_fall && s_r.mode == PMS_REDUCED) begin
            s_nxt.mav_ok = 1'b1;
        end

        if (req_v && req != s_r.mode) begin
            if (req == PMS_LOW && s_r.gain != GAIN_OK_A && s_r.gain != GAIN_OK_B) begin
                s_nxt.refused = 1'b1;
            end else begin
                s_nxt.mode = req;
                s_nxt.pins = pms_encode(req);
                if (req == PMS_REDUCED) begin
                    s_nxt.mav_ok = (s_r.mode == PMS_NORMAL);
                end
                if (req == PMS_NORMAL) begin
                    s_nxt.gain = GAIN_RST;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.mode <= PMS_NORMAL;
            s_r.pins <= PIN_NORMAL;
            s_r.gain <= GAIN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.mode_hi = s_r.pins[1];
    assign link.mode_lo = s_r.pins[0];
    assign link.sp_addr = s_r.sp_addr;
    assign link.sp_wdata = s_r.sp_wdata;
    assign link.sp_wr = s_r.sp_wr;
    assign link.sp_rd = s_r.sp_rd;
    assign rdata_o = s_r.urdata;

endmodule // pms_host

// *** tb/pms_checker.sv ***
// pms_checker: concurrent checks on the host to sequencer link and sequencer status.
// assumes one clock domain; the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module pms_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link signals
    input wire logic mode_hi,
    input wire logic mode_lo,
    input wire logic irq_a_n,
    input wire logic irq_b_n,
    input wire logic [pms_pkg::ADDR_W-1:0] sp_addr,
    input wire logic [pms_pkg::DATA_W-1:0] sp_wdata,
    input wire logic sp_wr,
    input wire logic sp_rd,
    input wire logic [pms_pkg::DATA_W-1:0] sp_rdata,
    // sequencer status
    input wire pms_pkg::pms_mode_t mode_o,
    input wire logic busy_o
);
    import pms_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] pins;
    logic mav_hit;
    pms_mode_t pin_mode;
    assign pins = {mode_hi, mode_lo};
    assign mav_hit = sp_addr == REG_MAV_A || sp_addr == REG_MAV_B || sp_addr == REG_MAV_C;
    always_comb begin
        case (pins)
            PIN_NORMAL: pin_mode = PMS_NORMAL;
            PIN_REDUCED: pin_mode = PMS_REDUCED;
            PIN_LOW: pin_mode = PMS_LOW;
            default: pin_mode = PMS_SLEEP;
        endcase
    end
    property p_decode;
        $stable(pins) [*4] |-> mode_o == pin_mode;
    endproperty
    a_decode: assert property (p_decode) else $error("mode does not follow pins");
    property p_busy_len;
        $rose(busy_o) |-> ##39 busy_o ##1 !busy_o;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("transition length wrong");
    property p_busy_quiet;
        busy_o |-> irq_a_n && irq_b_n;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("line low in transition");
    property p_done_end;
        $fell(busy_o) && mode_o == PMS_NORMAL |-> !irq_b_n;
    endproperty
    a_done_end: assert property (p_done_end) else $error("no done interrupt");
    property p_mav_start;
        $fell(busy_o) && mode_o == PMS_REDUCED |-> !irq_b_n;
    endproperty
    a_mav_start: assert property (p_mav_start) else $error("no mean start signal");
    property p_done_clear;
        sp_wr && sp_addr == REG_STATUS_B && sp_wdata[DONE_BIT] && mode_o == PMS_NORMAL
            && pins == PIN_NORMAL && !busy_o |=> irq_b_n;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("line b not released");
    property p_red_read;
        sp_rd && mode_o == PMS_REDUCED && !mav_hit |=> sp_rdata == '0;
    endproperty
    a_red_read: assert property (p_red_read) else $error("reduced read not blank");
    property p_lp_read;
        sp_rd && (mode_o == PMS_LOW || mode_o == PMS_SLEEP) |=> sp_rdata == '0;
    endproperty
    a_lp_read: assert property (p_lp_read) else $error("port answered in low mode");
    property p_a_line;
        !irq_a_n |-> mode_o == PMS_LOW && irq_b_n;
    endproperty
    a_a_line: assert property (p_a_line) else $error("line a low wrongly");
    c_done: cover property ($fell(busy_o) && mode_o == PMS_NORMAL);
    c_quiet: cover property ($fell(irq_a_n));
    c_mav: cover property ($fell(busy_o) && mode_o == PMS_REDUCED);
endmodule // pms_checker

// *** tb/power_mode_sequencer_test.sv ***
// power_mode_sequencer_test: host and sequencer joined by the link, driven
// through the host software port; assumes the window unit shortened to 20 cycles.
`timescale 1ns/1ps
module power_mode_sequencer_test;
    import pms_pkg::*;
    typedef struct {logic [31:0] e; logic [31:0] m;} pms_note_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_q = 1'b0;
    logic [31:0] rdata_o;
    logic sample_valid_i = 1'b1;
    logic [2:0][23:0] ph_net_i = '0;
    logic [2:0][23:0] ph_pos_i = '0;
    logic [2:0] hi = 3'h0;
    pms_mode_t mode_o;
    logic busy_o;
    pms_note_t notes[$];
    int mismatches = 0;
    int tests_run = 0;
    int seed = 44;
    int n;
    pms_link_if link_bus();
    pms_device #(.LP_UNIT_CYC(20)) pms_device_inst (.clk_i(clk_i), .rst_i(rst_i),
        .link(link_bus), .sample_valid_i(sample_valid_i), .ph_net_i(ph_net_i),
        .ph_pos_i(ph_pos_i), .mode_o(mode_o), .busy_o(busy_o));
    pms_host pms_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_bus), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    pms_checker pms_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_hi(link_bus.mode_hi),
        .mode_lo(link_bus.mode_lo), .irq_a_n(link_bus.irq_a_n), .irq_b_n(link_bus.irq_b_n),
        .sp_addr(link_bus.sp_addr), .sp_wdata(link_bus.sp_wdata), .sp_wr(link_bus.sp_wr),
        .sp_rd(link_bus.sp_rd), .sp_rdata(link_bus.sp_rdata), .mode_o(mode_o), .busy_o(busy_o));
    always #12.5 clk_i = ~clk_i;
    // quiet phases stay far under the threshold, a raised phase far over it
    always @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            ph_net_i[k] <= 24'($random(seed));
            ph_pos_i[k] <= hi[k] ? 24'h7FFFF0 : 24'($random(seed)) & 24'h0FFFFF;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    always @(posedge clk_i) begin
        if (rd_q) begin
            check("rdata_o", notes[0].e, rdata_o & notes[0].m);
            notes.delete(0);
        end
        rd_q <= rd_i;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        notes.push_back('{e & m, m});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic dread(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        wr(H_CMD, {24'h0, a});
        @(posedge clk_i);
        rd(H_DATA, e, m);
    endtask
    task automatic dwrite(input logic [7:0] a, input logic [31:0] d);
        wr(H_DATA, d);
        wr(H_CMD, {23'h0, 1'b1, a});
    endtask
    function automatic logic cond(input int s);
        case (s)
            0: cond = busy_o;
            1: cond = !busy_o;
            2: cond = !link_bus.irq_b_n;
            default: cond = !link_bus.irq_a_n || !link_bus.irq_b_n;
        endcase
    endfunction
    task automatic wait_for(input int s, output int c);
        c = 0;
        while (!cond(s) && c < 400) begin
            @(posedge clk_i);
            c++;
        end
        if (c == 400) check("wait", 32'h1, 32'h0);
    endtask
    task automatic set_mode(input logic [2:0] c, input logic [1:0] p, input pms_mode_t m);
        wr(H_CTRL, {29'h0, c});
        // a read sent right after the switch meets the new mode in the host and the transition in the sequencer
        wr(H_CMD, {24'h0, REG_LP_LEVEL});
        repeat (6) @(posedge clk_i);
        check("pins", {30'h0, p}, {30'h0, link_bus.mode_hi, link_bus.mode_lo});
        check("mode_o", {30'h0, m}, {30'h0, mode_o});
    endtask
    task automatic pulse(input int k);
        repeat (k) begin
            hi <= 3'h2;
            @(posedge clk_i);
            hi <= 3'h0;
            repeat (2) @(posedge clk_i);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        check("watchdog", 32'h1, 32'h0);
        complete_run;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        dread(REG_STATUS_B, 32'h0, 32'h8000);
        dread(REG_LP_LEVEL, 32'h07, 32'hFF);
        dread(REG_GAIN, 32'h1, 32'h7);
        dread(8'h40, 32'h0, 32'hFFFFFFFF);
        dread(REG_MAV_B, 32'h0, 32'hFFF00000);
        dwrite(REG_LP_LEVEL, 32'h0B);
        dwrite(REG_SECONDARY_CONFIG_REG, 32'h5A);
        dwrite(REG_MASK_B, 32'hFFFF);
        dwrite(REG_GAIN, 32'h4);
        set_mode(3'h2, PIN_NORMAL, PMS_NORMAL);
        rd(H_STAT, 32'h10, 32'h10);
        wr(H_STAT, 32'h1C);
        set_mode(3'h1, PIN_REDUCED, PMS_REDUCED);
        check("busy_o", 32'h0, {31'h0, busy_o});
        dread(REG_MAV_A, 32'h0, 32'hFFF00000);
        wr(H_CMD, {24'h0, REG_LP_LEVEL});
        rd(H_STAT, 32'h30, 32'h30);
        wr(H_STAT, 32'h1C);
        set_mode(3'h0, PIN_NORMAL, PMS_NORMAL);
        check("irq_b_n", 32'h1, {31'h0, link_bus.irq_b_n});
        wait_for(2, n);
        dread(REG_STATUS_B, 32'h8000, 32'h8000);
        dread(REG_LP_LEVEL, 32'h0B, 32'hFF);
        dread(REG_SECONDARY_CONFIG_REG, 32'h5A, 32'hFF);
        dread(REG_MASK_B, 32'h0, 32'hFFFF);
        dread(REG_GAIN, 32'h1, 32'h7);
        dwrite(REG_MASK_B, 32'hFFFF);
        check("irq_b_n", 32'h0, {31'h0, link_bus.irq_b_n});
        dwrite(REG_STATUS_B, 32'h8000);
        repeat (3) @(posedge clk_i);
        check("irq_b_n", 32'h1, {31'h0, link_bus.irq_b_n});
        dread(REG_STATUS_B, 32'h0, 32'h8000);
        wr(H_STAT, 32'h1C);
        // one crossing stays under period + 1 = 2
        set_mode(3'h2, PIN_LOW, PMS_LOW);
        wait_for(1, n);
        pulse(1);
        wait_for(3, n);
        check("window", 32'h1, {31'h0, n >= 35 && n <= 39});
        check("irq_a_n", 32'h0, {31'h0, link_bus.irq_a_n});
        wr(H_CMD, {24'h0, REG_STATUS_B});
        rd(H_STAT, 32'h15, 32'h1F);
        set_mode(3'h3, PIN_SLEEP, PMS_SLEEP);
        wait_for(1, n);
        set_mode(3'h0, PIN_NORMAL, PMS_NORMAL);
        wait_for(2, n);
        dwrite(REG_STATUS_B, 32'h8000);
        wr(H_STAT, 32'h1C);
        // two crossings reach the count; the host answers on its own
        set_mode(3'h6, PIN_LOW, PMS_LOW);
        wait_for(1, n);
        pulse(2);
        wait_for(3, n);
        check("irq_b_n", 32'h0, {31'h0, link_bus.irq_b_n});
        check("irq_a_n", 32'h1, {31'h0, link_bus.irq_a_n});
        wait_for(0, n);
        wait_for(1, n);
        check("mode_o", {30'h0, PMS_REDUCED}, {30'h0, mode_o});
        check("irq_b_n", 32'h0, {31'h0, link_bus.irq_b_n});
        dread(REG_MAV_C, 32'h0, 32'hFFF00000);
        complete_run;
    end
endmodule // power_mode_sequencer_test
